// file: rtl/ethmac_status_config.sv
// status, configuration and station address logic of the ethernet mac
`timescale 1ns/100ps
module ethmac_status_config (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [1:0] reg_size,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic rx_packet_done,
	input wire logic [7:0] rx_desc_used,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic [15:0] station_factory,
	input wire logic [3:0] mac_txd,
	input wire logic mac_tx_en,
	input wire logic [3:0] phy_rxd,
	input wire logic phy_rx_dv,
	output logic [3:0] mac_rxd,
	output logic mac_rx_dv,
	output logic [3:0] phy_txd,
	output logic phy_tx_en,
	output logic [7:0] packet_buffer_counter,
	output logic module_on,
	output logic flow_control_on,
	output logic rx_halt,
	output logic packet_pending_flag,
	output logic packet_pending_irq,
	output logic module_busy,
	output logic transmit_busy,
	output logic receive_busy,
	output logic mac_and_media_interface_reset,
	output logic tx_random_generator_reset,
	output logic rx_control_sublayer_reset,
	output logic rx_function_reset,
	output logic tx_control_sublayer_reset,
	output logic tx_function_reset,
	output logic mac_loopback,
	output logic transmit_flow_control_allow,
	output logic receive_flow_control_act,
	output logic accept_every_frame,
	output logic mac_receive_on
);
	import ethmac_pkg::*;

	typedef struct packed {
		logic [31:0] ctl;
		logic [31:0] rxst;
		logic [31:0] cfg;
		logic [31:0] sa;
		logic [31:0] irq;
		logic [7:0] cnt;
		logic loaded;
		logic [31:0] rdata;
		logic [3:0] rxd_s1;
		logic [3:0] rxd_s2;
		logic dv_s1;
		logic dv_s2;
		logic [3:0] mac_rxd;
		logic mac_rx_dv;
		logic [3:0] phy_txd;
		logic phy_tx_en;
	} state_t;

	localparam state_t STATE_RST = '{
		ctl: CTL_RST,
		rxst: RXST_RST,
		cfg: CFG_RST,
		sa: SA_RST,
		irq: IRQ_RST,
		cnt: CNT_ZERO,
		loaded: 1'b0,
		rdata: WORD_ZERO,
		rxd_s1: NIB_ZERO,
		rxd_s2: NIB_ZERO,
		dv_s1: 1'b0,
		dv_s2: 1'b0,
		mac_rxd: NIB_ZERO,
		mac_rx_dv: 1'b0,
		phy_txd: NIB_ZERO,
		phy_tx_en: 1'b0
	};

	state_t s_q;
	state_t s_d;

	logic lane_ok;
	logic [31:0] lane_mask;
	logic [1:0] alias_sel;
	logic [7:0] reg_sel;
	logic wr_ok;
	logic rd_ok;
	logic hit_ctl;
	logic hit_rxst;
	logic hit_cfg;
	logic hit_sa;
	logic hit_irq;
	logic dec_req;
	logic inc_req;
	logic [8:0] inc_sum;
	logic [7:0] inc_val;
	logic [7:0] dec_val;
	logic [31:0] stat_word;
	logic [31:0] irq_word;
	logic soft_rst;
	logic rx_path_rst;
	logic tx_path_rst;

	// apply one write through its alias, touching only writable lane bits
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [31:0] mask,
		input logic [1:0] kind
	);
		logic [31:0] nv;
		nv = old;
		case (kind)
			ALIAS_PLAIN: nv = (old & ~mask) | (wd & mask);
			ALIAS_CLR: nv = old & ~(wd & mask);
			ALIAS_SET: nv = old | (wd & mask);
			ALIAS_INV: nv = old ^ (wd & mask);
			default: nv = old;
		endcase
		return nv;
	endfunction

	// byte accesses get no lane at all, so they never land anywhere
	always_comb begin
		lane_ok = 1'b0;
		lane_mask = WORD_ZERO;
		case (reg_size)
			SIZE_HALF: begin
				lane_ok = 1'b1;
				lane_mask = reg_addr[1] ? LANE_HI : LANE_LO;
			end
			SIZE_WORD: begin
				lane_ok = 1'b1;
				lane_mask = LANE_ALL;
			end
			default: begin
				lane_ok = 1'b0;
				lane_mask = WORD_ZERO;
			end
		endcase
	end

	// address decode
	assign alias_sel = reg_addr[3:2];
	assign reg_sel = reg_addr & OFS_REG_MASK;
	assign wr_ok = reg_wr & lane_ok;
	assign rd_ok = reg_rd & lane_ok;
	assign hit_ctl = reg_sel == OFS_CTL;
	assign hit_rxst = reg_sel == OFS_RXST;
	assign hit_cfg = reg_sel == OFS_CFG;
	assign hit_sa = reg_sel == OFS_SA;
	assign hit_irq = reg_sel == OFS_IRQ;

	// decrement strobe: a one written to the bit by plain, set or invert
	always_comb begin
		dec_req = 1'b0;
		if (wr_ok && hit_ctl && alias_sel != ALIAS_CLR) begin
			dec_req = reg_wdata[CTL_DEC] & lane_mask[CTL_DEC];
		end
	end

	// saturating arithmetic on the packet-buffer counter
	assign inc_req = rx_packet_done;
	assign inc_sum = {1'b0, s_q.cnt} + {1'b0, rx_desc_used};
	assign inc_val = inc_sum[8] ? CNT_MAX : inc_sum[7:0];
	assign dec_val = (s_q.cnt == CNT_ZERO) ? CNT_ZERO :
		s_q.cnt - CNT_ONE;

	// read-only views
	always_comb begin
		stat_word = WORD_ZERO;
		stat_word[STAT_CNT_LSB +: 8] = s_q.cnt;
		stat_word[STAT_MBUSY] = module_busy;
		stat_word[STAT_TBUSY] = transmit_busy;
		stat_word[STAT_RBUSY] = receive_busy;
		irq_word = s_q.irq;
		irq_word[IRQ_PEND] = packet_pending_flag;
	end

	// mac sub-block reset levels
	assign soft_rst = s_q.cfg[CFG_SOFT];
	assign rx_path_rst = soft_rst | s_q.cfg[CFG_RFUN];
	assign tx_path_rst = soft_rst | s_q.cfg[CFG_TFUN];

	// next state of every register
	always_comb begin
		s_d = s_q;

		// register writes; aliases share the same write path
		if (wr_ok && hit_ctl) begin
			s_d.ctl = merge(s_q.ctl, reg_wdata,
				CTL_WMASK & lane_mask, alias_sel);
		end
		if (wr_ok && hit_rxst) begin
			s_d.rxst = merge(s_q.rxst, reg_wdata,
				RXST_WMASK & lane_mask, alias_sel);
		end
		if (wr_ok && hit_cfg) begin
			s_d.cfg = merge(s_q.cfg, reg_wdata,
				CFG_WMASK & lane_mask, alias_sel);
		end
		if (wr_ok && hit_irq) begin
			s_d.irq = merge(s_q.irq, reg_wdata,
				IRQ_WMASK & lane_mask, alias_sel);
		end

		// factory address is taken one edge after reset release
		if (!s_q.loaded) begin
			s_d.loaded = 1'b1;
			s_d.sa = {16'h0000, station_factory};
		end else if (wr_ok && hit_sa) begin
			s_d.sa = merge(s_q.sa, reg_wdata,
				SA_WMASK & lane_mask, alias_sel);
		end

		// module on/off has no effect on the count
		// receive-start write wins; the pointer moved, old count is void
		if (wr_ok && hit_rxst) begin
			s_d.cnt = CNT_ZERO;
		end else if (inc_req && dec_req) begin
			s_d.cnt = s_q.cnt;
		end else if (inc_req) begin
			s_d.cnt = inc_val;
		end else if (dec_req) begin
			s_d.cnt = dec_val;
		end

		// read data stands only in the cycle after the strobe
		s_d.rdata = WORD_ZERO;
		if (rd_ok && alias_sel == ALIAS_PLAIN) begin
			case (reg_sel)
				OFS_CTL: s_d.rdata = s_q.ctl & lane_mask;
				OFS_RXST: s_d.rdata = s_q.rxst & lane_mask;
				OFS_STAT: s_d.rdata = stat_word & lane_mask;
				OFS_CFG: s_d.rdata = s_q.cfg & lane_mask;
				OFS_SA: s_d.rdata = s_q.sa & lane_mask;
				OFS_IRQ: s_d.rdata = irq_word & lane_mask;
				default: s_d.rdata = WORD_ZERO;
			endcase
		end

		// phy receive pins pass two flops before use
		s_d.rxd_s1 = phy_rxd;
		s_d.rxd_s2 = s_q.rxd_s1;
		s_d.dv_s1 = phy_rx_dv;
		s_d.dv_s2 = s_q.dv_s1;

		// receive side: loopback takes the mac's own transmit stream
		if (rx_path_rst) begin
			s_d.mac_rxd = NIB_ZERO;
			s_d.mac_rx_dv = 1'b0;
		end else if (s_q.cfg[CFG_LOOP]) begin
			s_d.mac_rxd = mac_txd;
			s_d.mac_rx_dv = mac_tx_en & s_q.cfg[CFG_RXEN];
		end else begin
			s_d.mac_rxd = s_q.rxd_s2;
			s_d.mac_rx_dv = s_q.dv_s2 & s_q.cfg[CFG_RXEN];
		end

		// transmit side stays quiet on the wire during loopback
		if (tx_path_rst || s_q.cfg[CFG_LOOP]) begin
			s_d.phy_txd = NIB_ZERO;
			s_d.phy_tx_en = 1'b0;
		end else begin
			s_d.phy_txd = mac_txd;
			s_d.phy_tx_en = mac_tx_en;
		end
	end

	// the only clocked process
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// register bus answer
	assign reg_rdata = s_q.rdata;

	// counter, flow control and pending status
	assign packet_buffer_counter = s_q.cnt;
	assign module_on = s_q.ctl[CTL_ON];
	assign flow_control_on = s_q.ctl[CTL_AFC];
	// halt is released as soon as a decrement drops below the top
	assign rx_halt = s_q.ctl[CTL_AFC] & (s_q.cnt == CNT_MAX);
	assign packet_pending_flag = s_q.cnt != CNT_ZERO;
	assign packet_pending_irq = packet_pending_flag &
		s_q.irq[IRQ_IE];

	// busy indicators; an active path keeps module_busy after switch-off
	assign module_busy = s_q.ctl[CTL_ON] | tx_active | rx_active;
	assign transmit_busy = s_q.ctl[CTL_ON] & tx_active;
	assign receive_busy = s_q.ctl[CTL_ON] & rx_active;

	// configuration levels toward the mac
	assign mac_and_media_interface_reset = soft_rst;
	assign tx_random_generator_reset = s_q.cfg[CFG_SIM];
	assign rx_control_sublayer_reset = s_q.cfg[CFG_RMCS];
	assign rx_function_reset = s_q.cfg[CFG_RFUN];
	assign tx_control_sublayer_reset = s_q.cfg[CFG_TMCS];
	assign tx_function_reset = s_q.cfg[CFG_TFUN];
	assign mac_loopback = s_q.cfg[CFG_LOOP];
	assign transmit_flow_control_allow = s_q.cfg[CFG_TXP];
	assign receive_flow_control_act = s_q.cfg[CFG_RXP];
	assign accept_every_frame = s_q.cfg[CFG_PASS];
	assign mac_receive_on = s_q.cfg[CFG_RXEN];

	// mii data outputs straight from flops
	assign mac_rxd = s_q.mac_rxd;
	assign mac_rx_dv = s_q.mac_rx_dv;
	assign phy_txd = s_q.phy_txd;
	assign phy_tx_en = s_q.phy_tx_en;
endmodule

// file: rtl/ethmac_pkg.sv
// constants shared by the ethernet status and configuration block
package ethmac_pkg;
	// register word offsets, each writable one with clear/set/invert aliases after it
	localparam logic [7:0] OFS_CTL = 8'h00;
	localparam logic [7:0] OFS_RXST = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h20;
	localparam logic [7:0] OFS_CFG = 8'h30;
	localparam logic [7:0] OFS_SA = 8'h40;
	localparam logic [7:0] OFS_IRQ = 8'h50;
	localparam logic [7:0] OFS_REG_MASK = 8'hF0;
	// alias selector in address bits 3:2
	localparam logic [1:0] ALIAS_PLAIN = 2'h0;
	localparam logic [1:0] ALIAS_CLR = 2'h1;
	localparam logic [1:0] ALIAS_SET = 2'h2;
	localparam logic [1:0] ALIAS_INV = 2'h3;
	// access size codes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [31:0] LANE_LO = 32'h0000FFFF;
	localparam logic [31:0] LANE_HI = 32'hFFFF0000;
	localparam logic [31:0] LANE_ALL = 32'hFFFFFFFF;
	// control one fields
	localparam int CTL_ON = 15;
	localparam int CTL_AFC = 7;
	localparam int CTL_DEC = 0;
	localparam logic [31:0] CTL_WMASK = 32'h00008080;
	localparam logic [31:0] CTL_RST = 32'h00000000;
	// receive start address, word aligned
	localparam logic [31:0] RXST_WMASK = 32'hFFFFFFFC;
	localparam logic [31:0] RXST_RST = 32'h00000000;
	// status fields
	localparam int STAT_CNT_LSB = 16;
	localparam int STAT_MBUSY = 7;
	localparam int STAT_TBUSY = 6;
	localparam int STAT_RBUSY = 5;
	// mac configuration one fields
	localparam int CFG_SOFT = 15;
	localparam int CFG_SIM = 14;
	localparam int CFG_RMCS = 11;
	localparam int CFG_RFUN = 10;
	localparam int CFG_TMCS = 9;
	localparam int CFG_TFUN = 8;
	localparam int CFG_LOOP = 4;
	localparam int CFG_TXP = 3;
	localparam int CFG_RXP = 2;
	localparam int CFG_PASS = 1;
	localparam int CFG_RXEN = 0;
	localparam logic [31:0] CFG_WMASK = 32'h0000CF1F;
	localparam logic [31:0] CFG_RST = 32'h0000800D;
	// station address middle
	localparam logic [31:0] SA_WMASK = 32'h0000FFFF;
	localparam logic [31:0] SA_RST = 32'h00000000;
	// interrupt enable and pending flag
	localparam int IRQ_IE = 0;
	localparam int IRQ_PEND = 1;
	localparam logic [31:0] IRQ_WMASK = 32'h00000001;
	localparam logic [31:0] IRQ_RST = 32'h00000000;
	// counter limits
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;
endpackage

// file: bench/ethmac_checker.sv
// port assertions for the ethernet status and configuration block
`timescale 1ns/100ps
module ethmac_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [1:0] reg_size,
	input wire logic reg_wr,
	input wire logic rx_packet_done,
	input wire logic [7:0] rx_desc_used,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic [7:0] packet_buffer_counter,
	input wire logic module_on,
	input wire logic flow_control_on,
	input wire logic rx_halt,
	input wire logic packet_pending_flag,
	input wire logic module_busy,
	input wire logic transmit_busy,
	input wire logic mac_loopback
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// helpers: short counter name, widened sum, half or word size
	wire logic [7:0] c = packet_buffer_counter;
	wire logic [8:0] sum = {1'b0, c} + {1'b0, rx_desc_used};
	wire logic vs = reg_size[1] ^ reg_size[0];
	a_inc_adds: assert property (rx_packet_done && !reg_wr && !sum[8]
		|=> c == $past(sum[7:0])) else $error("counter add wrong");
	a_sat_max: assert property (rx_packet_done && !reg_wr && sum[8]
		|=> c == 8'hFF) else $error("counter wrapped at top");
	a_floor_zero: assert property (c == 8'h00 && !rx_packet_done
		|=> c == 8'h00) else $error("counter wrapped at zero");
	a_both_hold: assert property (rx_packet_done && reg_wr && vs &&
		reg_addr == 8'h08 && reg_wdata[0] |=> $stable(c))
		else $error("inc with dec changed counter");
	a_halt_full: assert property (rx_halt ==
		(flow_control_on && c == 8'hFF)) else $error("halt wrong");
	a_pend_nonzero: assert property (packet_pending_flag ==
		(c != 8'h00)) else $error("pending flag wrong");
	a_rxst_clear: assert property (reg_wr && vs &&
		reg_addr[7:4] == 4'h1 |=> c == 8'h00)
		else $error("start address write kept counter");
	a_off_keeps: assert property ($fell(module_on) &&
		!$past(rx_packet_done) && !$past(reg_wdata[0]) |-> $stable(c))
		else $error("switch off changed counter");
	a_busy_on: assert property (module_busy ==
		(module_on || tx_active || rx_active)) else $error("busy wrong");
	a_tx_busy: assert property (transmit_busy ==
		(module_on && tx_active)) else $error("tx busy wrong");
	a_byte_ignored: assert property (reg_wr && reg_size == 2'h0 &&
		!rx_packet_done |=> $stable(c) && $stable(mac_loopback))
		else $error("byte write took effect");
endmodule
bind ethmac_status_config ethmac_checker chk (.mclk, .rst_n, .reg_addr,
	.reg_wdata, .reg_size, .reg_wr, .rx_packet_done, .rx_desc_used,
	.tx_active, .rx_active, .packet_buffer_counter, .module_on,
	.flow_control_on, .rx_halt, .packet_pending_flag, .module_busy,
	.transmit_busy, .mac_loopback);

// file: bench/phy_model.sv
// media-side partner: sends receive nibbles, keeps last transmit nibble
`timescale 1ns/100ps
module phy_model (
	input wire logic mclk,
	input wire logic [3:0] phy_txd,
	input wire logic phy_tx_en,
	output logic [3:0] phy_rxd,
	output logic phy_rx_dv,
	output logic [3:0] tx_seen
);
	initial begin
		phy_rxd = 4'h5;
		phy_rx_dv = 1'b0;
		tx_seen = 4'h0;
	end
	// only nibbles framed by the enable count as sent
	always @(posedge mclk) begin
		if (phy_tx_en) begin
			tx_seen <= phy_txd;
		end
	end
	// idle line shows the inverse so a stale nibble cannot pass
	task automatic send(input logic [3:0] d);
		@(posedge mclk);
		phy_rxd <= d;
		phy_rx_dv <= 1'b1;
		@(posedge mclk);
		phy_rxd <= ~d;
		phy_rx_dv <= 1'b0;
	endtask
endmodule

// file: bench/ethernet_mac_status_and_config_tb.sv
// self-checking bench for the ethernet status and configuration block
`timescale 1ns/100ps
module ethernet_mac_status_and_config_tb;
	import ethmac_pkg::*;
	logic mclk, rst_n, reg_wr, reg_rd, rx_packet_done, tx_active;
	logic rx_active, mac_tx_en, phy_rx_dv, mac_rx_dv, phy_tx_en;
	logic module_on, flow_control_on, rx_halt, packet_pending_flag;
	logic packet_pending_irq, module_busy, transmit_busy, receive_busy;
	logic mac_and_media_interface_reset, tx_random_generator_reset;
	logic rx_control_sublayer_reset, rx_function_reset, mac_loopback;
	logic tx_control_sublayer_reset, tx_function_reset, mac_receive_on;
	logic transmit_flow_control_allow, receive_flow_control_act;
	logic accept_every_frame;
	logic [1:0] reg_size;
	logic [3:0] mac_txd, phy_rxd, mac_rxd, phy_txd, tx_seen;
	logic [7:0] reg_addr, rx_desc_used, packet_buffer_counter, seed;
	logic [15:0] station_factory;
	logic [31:0] reg_wdata, reg_rdata, rdv;
	int err_count, n_compared, cyc, cnt_m;
	bit afc;
	wire logic [10:0] cfg_o = {mac_and_media_interface_reset,
		tx_random_generator_reset, rx_control_sublayer_reset,
		rx_function_reset, tx_control_sublayer_reset, tx_function_reset,
		mac_loopback, transmit_flow_control_allow,
		receive_flow_control_act, accept_every_frame, mac_receive_on};
	ethmac_status_config dut (.*);
	phy_model phy (.mclk, .phy_txd, .phy_tx_en, .phy_rxd, .phy_rx_dv,
		.tx_seen);
	always #2 mclk = ~mclk;
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic chkp(input logic [15:0] g, input logic [15:0] e);
		chk32({16'h0000, g}, {16'h0000, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] s);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_size <= s;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_size <= SIZE_WORD;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		rdv = reg_rdata;
	endtask
	// increment and set-alias decrement may land on the same edge
	task automatic ev(input bit inc, input int d, input bit dec);
		@(posedge mclk);
		rx_packet_done <= inc;
		rx_desc_used <= d[7:0];
		reg_wr <= dec;
		reg_addr <= 8'h08;
		reg_wdata <= 32'h00000001;
		reg_size <= SIZE_WORD;
		@(posedge mclk);
		rx_packet_done <= 1'b0;
		reg_wr <= 1'b0;
		@(negedge mclk);
		cnt_m = (inc && !dec) ? ((cnt_m + d > 255) ? 255 : cnt_m + d) :
			(dec && !inc && cnt_m > 0) ? cnt_m - 1 : cnt_m;
		chkp(packet_buffer_counter, cnt_m[7:0]);
		chkp(rx_halt, afc && cnt_m == 255);
		chkp(packet_pending_flag, cnt_m != 0);
	endtask
	initial begin
		{mclk, rst_n, reg_wr, reg_rd, rx_packet_done, tx_active} = 6'h00;
		{rx_active, mac_tx_en, reg_size, mac_txd, reg_addr} = 16'h0000;
		{rx_desc_used, reg_wdata, err_count, n_compared, cyc} = 0;
		station_factory = 16'hC3A5;
		seed = 8'h56;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		// reset values, factory address, unmapped place
		rd(OFS_CFG);
		chk32(rdv, 32'h0000800D);
		rd(OFS_SA);
		chk32(rdv, 32'h0000C3A5);
		rd(8'h60);
		chk32(rdv, 32'h00000000);
		// every bit alone, reserved ones must not stick
		for (int b = 0; b < 16; b++) begin
			wr(OFS_CFG, 32'h1 << b, SIZE_WORD);
			rdv = 32'h1 << b;
			rdv = {21'h0, rdv[15:14], rdv[11:8], rdv[4:0]};
			chkp(cfg_o, rdv[15:0]);
		end
		wr(OFS_CFG, 32'h0, SIZE_BYTE);
		wr(8'h32, 32'hFFFF0000, SIZE_HALF);
		chkp(cfg_o, 16'h0400);
		wr(OFS_SA, 32'h00005AA5, SIZE_HALF);
		wr(OFS_SA, 32'h0, SIZE_BYTE);
		rd(OFS_SA);
		chk32(rdv, 32'h00005AA5);
		$display("config test done");
		// loopback, then both directions through the partner
		wr(OFS_CFG, 32'h00000011, SIZE_HALF);
		mac_txd <= 4'hA;
		mac_tx_en <= 1'b1;
		@(negedge mclk);
		chkp({mac_rx_dv, mac_rxd, phy_tx_en}, 6'h34);
		wr(OFS_CFG, 32'h00000001, SIZE_WORD);
		// wire output flops one edge later, the partner sees it the next
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk32(tx_seen, 4'hA);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			phy.send(seed[3:0]);
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			chkp({mac_rx_dv, mac_rxd}, {1'b1, seed[3:0]});
		end
		mac_tx_en <= 1'b0;
		$display("media test done");
		// busy flags with the module on
		wr(OFS_CTL, 32'h00008080, SIZE_WORD);
		afc = 1;
		for (int k = 0; k < 4; k++) begin
			tx_active <= k[0];
			rx_active <= k[1];
			rd(OFS_STAT);
			chk32(rdv, {24'h0, 1'b1, k[0], k[1], 5'h0});
		end
		$display("busy test done");
		// counter edges, then random traffic
		ev(0, 0, 1);
		ev(1, 255, 0);
		ev(1, 5, 0);
		ev(1, 3, 1);
		ev(0, 0, 1);
		for (int i = 0; i < 60; i++) begin
			seed = lfsr(seed);
			ev(seed[0], seed[7:3], seed[1]);
		end
		rd(OFS_STAT);
		chk32(rdv[23:16], cnt_m);
		ev(1, 2, 0);
		wr(OFS_IRQ, 32'h00000001, SIZE_WORD);
		chkp(packet_pending_irq, 1'b1);
		rd(OFS_IRQ);
		chk32(rdv, 32'h00000003);
		wr(OFS_IRQ, 32'h0, SIZE_WORD);
		chkp(packet_pending_irq, 1'b0);
		$display("counter test done");
		// switch off: counter kept, no halt, busy tails tx
		tx_active <= 1'b1;
		wr(OFS_CTL, 32'h0, SIZE_WORD);
		afc = 0;
		chkp({module_busy, transmit_busy}, 2'h2);
		chkp(packet_buffer_counter, cnt_m[7:0]);
		ev(1, 255, 0);
		ev(0, 0, 1);
		wr(OFS_RXST, 32'h0, SIZE_BYTE);
		chkp(packet_buffer_counter, cnt_m[7:0]);
		wr(OFS_RXST + 8'h08, 32'h00001234, SIZE_WORD);
		cnt_m = 0;
		chkp(packet_buffer_counter, 8'h00);
		$display("off test done");
		end_sim();
	end
endmodule
